// file: rtl/lgs_pkg.sv
// lgs_pkg: constants, register map and types for the line gated set sequencer.
// assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
package lgs_pkg;

   // ==========================================================
   // sizes
   localparam int          DATA_W      = 32;
   localparam int          ADDR_W      = 8;
   localparam int          IDX_W       = 6;
   localparam int          CNT_W       = 7;
   localparam logic [6:0]  SET_MAX     = 7'h40;
   localparam logic [6:0]  SET_MIN     = 7'h01;

   // ==========================================================
   // timing
   localparam int          CLK_MHZ     = 100;
   localparam int          SETTLE_NS   = 1000;
   localparam int          SETTLE_CYC  = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0]  SETTLE_LOAD = 8'(SETTLE_CYC);

   // ==========================================================
   // register byte addresses
   localparam logic [7:0]  ADR_CTRL    = 8'h00;
   localparam logic [7:0]  ADR_TOTAL   = 8'h04;
   localparam logic [7:0]  ADR_STATUS  = 8'h08;
   localparam logic [7:0]  ADR_IRQ_ST  = 8'h0C;
   localparam logic [7:0]  ADR_IRQ_MSK = 8'h10;
   localparam logic [7:0]  ADR_SET_SEL = 8'h14;
   localparam logic [7:0]  ADR_SET_DAT = 8'h18;
   localparam logic [7:0]  ADR_BASE    = 8'h1C;
   localparam logic [7:0]  ADR_ACTIVE  = 8'h20;

   // ==========================================================
   // fields and reset values
   localparam int          CTRL_EN     = 0;
   localparam int          CTRL_INV    = 1;
   localparam int          EV_ACCEPT   = 0;
   localparam int          EV_IGNORE   = 1;
   localparam int          EV_WRAP     = 2;
   localparam int          EV_STOP     = 3;
   localparam int          EV_W        = 4;
   localparam logic [6:0]  TOTAL_RST   = 7'h40;
   localparam logic [31:0] BASE_RST    = 32'h0000_0000;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WAIT,
      ST_ACQ
   } lgs_state_t;

   typedef struct packed {
      logic invert;
      logic enable;
   } lgs_ctrl_t;

   typedef struct packed {
      logic [5:0] index;
      logic       busy;
      logic       waiting;
   } lgs_stat_t;

endpackage

// file: rtl/lgs_seq.sv
// lgs_seq: sequencer that steps stored parameter sets into the active set,
// gated by the level of a control line sampled at each frame start trigger.
// assumes FRAME_TRIG, CTRL_LINE and FRAME_DONE come from the same clock region
// and that software loads the set memory while the sequencer is off.
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module lgs_seq
   import lgs_pkg::*;
(
   input  wire logic              CLK_SYS,
   input  wire logic              RST_N,
   // ==== axi4-lite slave
   input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
   input  wire logic              S_AXI_AWVALID,
   output logic                   S_AXI_AWREADY,
   input  wire logic [DATA_W-1:0] S_AXI_WDATA,
   input  wire logic [3:0]        S_AXI_WSTRB,
   input  wire logic              S_AXI_WVALID,
   output logic                   S_AXI_WREADY,
   output logic [1:0]             S_AXI_BRESP,
   output logic                   S_AXI_BVALID,
   input  wire logic              S_AXI_BREADY,
   input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
   input  wire logic              S_AXI_ARVALID,
   output logic                   S_AXI_ARREADY,
   output logic [DATA_W-1:0]      S_AXI_RDATA,
   output logic [1:0]             S_AXI_RRESP,
   output logic                   S_AXI_RVALID,
   input  wire logic              S_AXI_RREADY,
   // ==== acquisition side
   input  wire logic              FRAME_TRIG,
   input  wire logic              CTRL_LINE,
   input  wire logic              FRAME_DONE,
   output logic                   WAIT_TRIG,
   output logic                   ACQ_START,
   output logic [IDX_W-1:0]       SET_INDEX,
   output logic [DATA_W-1:0]      ACTIVE_PARAM,
   output logic                   IRQ
);

   // ==========================================================
   // helpers
   function automatic logic [IDX_W-1:0] next_index(input logic [IDX_W-1:0] idx, input logic [CNT_W-1:0] total);
      if ({1'b0, idx} >= total - SET_MIN) begin
         next_index = '0;
      end else begin
         next_index = idx + 6'h01;
      end
   endfunction

   function automatic logic [CNT_W-1:0] clamp_total(input logic [DATA_W-1:0] v);
      if (v == 32'h0000_0000) begin
         clamp_total = SET_MIN;
      end else if (v > 32'(SET_MAX)) begin
         clamp_total = SET_MAX;
      end else begin
         clamp_total = v[CNT_W-1:0];
      end
   endfunction

   // ==========================================================
   // registers
   lgs_ctrl_t         ctrl_ff;
   logic [CNT_W-1:0]  total_ff;
   logic [EV_W-1:0]   irq_st_ff;
   logic [EV_W-1:0]   irq_msk_ff;
   logic [IDX_W-1:0]  set_sel_ff;
   logic [DATA_W-1:0] base_ff;
   logic [DATA_W-1:0] set_mem [SET_MAX];

   lgs_state_t        state_ff;
   logic [IDX_W-1:0]  idx_ff;
   logic [DATA_W-1:0] active_ff;
   logic [DATA_W-1:0] saved_ff;
   logic [7:0]        settle_ff;
   logic              trig_s1_ff;
   logic              trig_s2_ff;
   logic              trig_s3_ff;
   logic              line_s1_ff;
   logic              line_s2_ff;
   logic              line_s3_ff;
   logic [EV_W-1:0]   ev;

   // ==========================================================
   // axi4-lite write path
   logic              aw_hold_ff;
   logic              w_hold_ff;
   logic [ADDR_W-1:0] aw_addr_ff;
   logic [DATA_W-1:0] w_data_ff;
   logic              wr_go;
   logic              wr_hit;

   assign wr_go = aw_hold_ff && w_hold_ff && !S_AXI_BVALID;

   always_comb begin
      case (aw_addr_ff)
         ADR_CTRL, ADR_TOTAL, ADR_IRQ_ST, ADR_IRQ_MSK,
         ADR_SET_SEL, ADR_SET_DAT, ADR_BASE: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         aw_hold_ff    <= 1'b0;
         w_hold_ff     <= 1'b0;
         aw_addr_ff    <= '0;
         w_data_ff     <= '0;
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY  <= 1'b0;
         S_AXI_BVALID  <= 1'b0;
         S_AXI_BRESP   <= RESP_OKAY;
      end else begin
         S_AXI_AWREADY <= !aw_hold_ff && !S_AXI_AWREADY;
         S_AXI_WREADY  <= !w_hold_ff && !S_AXI_WREADY;
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_hold_ff    <= 1'b1;
            aw_addr_ff    <= {S_AXI_AWADDR[ADDR_W-1:2], 2'h0};
            S_AXI_AWREADY <= 1'b0;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_hold_ff    <= 1'b1;
            w_data_ff    <= S_AXI_WDATA;
            S_AXI_WREADY <= 1'b0;
         end
         if (wr_go) begin
            aw_hold_ff   <= 1'b0;
            w_hold_ff    <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
         end
      end
   end

   // byte strobes are ignored: every register is written as a whole word

   // ==========================================================
   // software registers
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         ctrl_ff    <= '0;
         total_ff   <= TOTAL_RST;
         irq_msk_ff <= '0;
         set_sel_ff <= '0;
         base_ff    <= BASE_RST;
      end else if (wr_go) begin
         case (aw_addr_ff)
            ADR_CTRL:    ctrl_ff    <= w_data_ff[1:0];
            ADR_TOTAL:   total_ff   <= clamp_total(w_data_ff);
            ADR_IRQ_MSK: irq_msk_ff <= w_data_ff[EV_W-1:0];
            ADR_SET_SEL: set_sel_ff <= w_data_ff[IDX_W-1:0];
            ADR_BASE:    base_ff    <= w_data_ff;
            default: ;
         endcase
      end
   end

   // set memory has no reset: contents are defined only after software writes them
   always_ff @(posedge CLK_SYS) begin
      if (wr_go && aw_addr_ff == ADR_SET_DAT) begin
         set_mem[set_sel_ff] <= w_data_ff;
      end
   end

   // ==========================================================
   // interrupt status, write one to clear; a new event wins over the clear
   logic [EV_W-1:0] clr;
   assign clr = (wr_go && aw_addr_ff == ADR_IRQ_ST) ? w_data_ff[EV_W-1:0] : '0;

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         irq_st_ff <= '0;
         IRQ       <= 1'b0;
      end else begin
         irq_st_ff <= (irq_st_ff & ~clr) | ev;
         IRQ       <= |(((irq_st_ff & ~clr) | ev) & irq_msk_ff);
      end
   end

   // ==========================================================
   // axi4-lite read path
   logic [DATA_W-1:0] rd_word;
   logic              rd_hit;
   lgs_stat_t         stat;

   assign stat = '{index: idx_ff, busy: (state_ff == ST_ACQ), waiting: WAIT_TRIG};

   always_comb begin
      rd_hit  = 1'b1;
      rd_word = '0;
      case ({S_AXI_ARADDR[ADDR_W-1:2], 2'h0})
         ADR_CTRL:    rd_word = 32'(ctrl_ff);
         ADR_TOTAL:   rd_word = 32'(total_ff);
         ADR_STATUS:  rd_word = 32'(stat);
         ADR_IRQ_ST:  rd_word = 32'(irq_st_ff);
         ADR_IRQ_MSK: rd_word = 32'(irq_msk_ff);
         ADR_SET_SEL: rd_word = 32'(set_sel_ff);
         ADR_SET_DAT: rd_word = set_mem[set_sel_ff];
         ADR_BASE:    rd_word = base_ff;
         ADR_ACTIVE:  rd_word = active_ff;
         default:     rd_hit  = 1'b0;
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID  <= 1'b0;
         S_AXI_RDATA   <= '0;
         S_AXI_RRESP   <= RESP_OKAY;
      end else begin
         S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY;
         if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b1;
            S_AXI_RDATA   <= rd_word;
            S_AXI_RRESP   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
         end
      end
   end

   // ==========================================================
   // input synchronisers and edge detection
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         trig_s1_ff <= 1'b0;
         trig_s2_ff <= 1'b0;
         trig_s3_ff <= 1'b0;
         line_s1_ff <= 1'b0;
         line_s2_ff <= 1'b0;
         line_s3_ff <= 1'b0;
      end else begin
         trig_s1_ff <= FRAME_TRIG;
         trig_s2_ff <= trig_s1_ff;
         trig_s3_ff <= trig_s2_ff;
         line_s1_ff <= CTRL_LINE;
         line_s2_ff <= line_s1_ff;
         line_s3_ff <= line_s2_ff;
      end
   end

   logic trig_edge;
   logic line_change;
   logic line_high;

   assign trig_edge   = trig_s2_ff && !trig_s3_ff;
   assign line_change = line_s2_ff ^ line_s3_ff;
   // same delay as the trigger path, so both are seen in one cycle
   assign line_high   = line_s2_ff ^ ctrl_ff.invert;

   // ==========================================================
   // line change hold-off: the status drops while the line settles
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         settle_ff <= '0;
      end else if (line_change) begin
         settle_ff <= SETTLE_LOAD;
      end else if (settle_ff != 8'h00) begin
         settle_ff <= settle_ff - 8'h01;
      end
   end

   // ==========================================================
   // sequencer
   logic             accept;
   logic [IDX_W-1:0] idx_nxt;

   assign accept  = (state_ff == ST_WAIT) && ctrl_ff.enable && WAIT_TRIG && trig_edge;
   assign idx_nxt = next_index(idx_ff, total_ff);

   always_comb begin
      ev = '0;
      ev[EV_ACCEPT] = accept;
      ev[EV_IGNORE] = trig_edge && !accept && (state_ff != ST_IDLE);
      ev[EV_WRAP]   = accept && line_high && (idx_nxt == 6'h00);
      ev[EV_STOP]   = (state_ff != ST_IDLE) && !ctrl_ff.enable && (state_ff == ST_WAIT || FRAME_DONE);
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         state_ff  <= ST_IDLE;
         idx_ff    <= '0;
         active_ff <= BASE_RST;
         saved_ff  <= BASE_RST;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               active_ff <= base_ff;
               if (ctrl_ff.enable) begin
                  saved_ff  <= base_ff;
                  idx_ff    <= '0;
                  active_ff <= set_mem[0];
                  state_ff  <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (!ctrl_ff.enable) begin
                  active_ff <= saved_ff;
                  state_ff  <= ST_IDLE;
               end else if (accept) begin
                  if (line_high) begin
                     idx_ff    <= idx_nxt;
                     active_ff <= set_mem[idx_nxt];
                  end
                  // low line: current set stays in force
                  state_ff <= ST_ACQ;
               end
            end
            ST_ACQ: begin
               // a disable only takes hold once the frame is complete
               if (FRAME_DONE) begin
                  if (!ctrl_ff.enable) begin
                     active_ff <= saved_ff;
                     state_ff  <= ST_IDLE;
                  end else begin
                     state_ff <= ST_WAIT;
                  end
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // registered outputs
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         WAIT_TRIG    <= 1'b0;
         ACQ_START    <= 1'b0;
         SET_INDEX    <= '0;
         ACTIVE_PARAM <= BASE_RST;
      end else begin
         // status drops in the same cycle the start pulse rises, so no second trigger looks welcome
         WAIT_TRIG    <= (state_ff == ST_WAIT) && ctrl_ff.enable && !accept && !line_change
                         && (settle_ff == 8'h00);
         ACQ_START    <= accept;
         SET_INDEX    <= idx_ff;
         ACTIVE_PARAM <= active_ff;
      end
   end

endmodule

`default_nettype wire

// file: test/lgs_seq_props.sv
// lgs_seq_props: port-level checks for lgs_seq.
// assumes a bind from the bench; sees top ports only.
`timescale 1ns/1ns
`default_nettype none
module lgs_seq_props
   import lgs_pkg::*;
(
   input wire logic             CLK_SYS,
   input wire logic             RST_N,
   input wire logic             S_AXI_ARVALID,
   input wire logic             S_AXI_ARREADY,
   input wire logic             S_AXI_RVALID,
   input wire logic             S_AXI_BVALID,
   input wire logic             S_AXI_BREADY,
   input wire logic             CTRL_LINE,
   input wire logic             WAIT_TRIG,
   input wire logic             ACQ_START,
   input wire logic [IDX_W-1:0] SET_INDEX
);
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RST_N);
   // ========
   // quiet time since the line last moved; saturates to stay small
   logic       line_ff;
   logic [7:0] quiet_ff;
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) line_ff <= 1'b0;
      else line_ff <= CTRL_LINE;
   end
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) quiet_ff <= 8'hFF;
      else if (CTRL_LINE != line_ff) quiet_ff <= 8'h00;
      else if (quiet_ff != 8'hFF) quiet_ff <= quiet_ff + 8'h01;
   end
   // ========
   property p_acq_pulse; ACQ_START |=> !ACQ_START; endproperty
   property p_acq_wait; ACQ_START |-> $past(WAIT_TRIG) && !WAIT_TRIG; endproperty
   property p_idx_cause; $changed(SET_INDEX) && SET_INDEX != 6'h00 |-> $past(ACQ_START); endproperty
   property p_idx_step;
      $changed(SET_INDEX) && SET_INDEX != 6'h00 |-> SET_INDEX == $past(SET_INDEX) + 6'h01;
   endproperty
   property p_line_drop; CTRL_LINE != line_ff |-> ##[1:5] !WAIT_TRIG; endproperty
   property p_settle; $rose(WAIT_TRIG) |-> quiet_ff >= 8'h5F; endproperty
   property p_r_ans; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
   property p_b_done; S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID; endproperty
   a_acq_pulse: assert property (p_acq_pulse)
      else $error("start pulse too long");
   a_acq_wait: assert property (p_acq_wait)
      else $error("start without waiting status");
   a_idx_cause: assert property (p_idx_cause)
      else $error("index moved without start");
   a_idx_step: assert property (p_idx_step)
      else $error("index skipped");
   a_line_drop: assert property (p_line_drop)
      else $error("waiting kept over line change");
   a_settle: assert property (p_settle)
      else $error("waiting back too soon");
   a_r_ans: assert property (p_r_ans)
      else $error("read answer late");
   a_b_done: assert property (p_b_done)
      else $error("write answer stuck");
   c_acq: cover property (ACQ_START);
   c_wrap: cover property ($changed(SET_INDEX) && SET_INDEX == 6'h00);
   c_drop: cover property ($fell(WAIT_TRIG));
endmodule
`default_nettype wire

// file: test/lgs_seq_test.sv
// lgs_seq_test: self-checking bench for the line gated set sequencer.
// assumes lgs_src as far side and lgs_seq_props bound to the design.
`timescale 1ns/1ns
`default_nettype none
module lgs_seq_test
   import lgs_pkg::*;
;
   logic        clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, trig, line, done, wait_t, acq, irq, inv_m;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, act, rdat;
   logic [1:0]  bresp, rresp, rsp;
   logic [5:0]  idx;
   int          fails, n_checks, n_acq, idx_m, tot_m, base_m, k, n0;
   int          mem [64];
   logic [9:0]  pat = 10'h2F2;
   lgs_seq DUT (.CLK_SYS(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .FRAME_TRIG(trig),
      .CTRL_LINE(line), .FRAME_DONE(done), .WAIT_TRIG(wait_t), .ACQ_START(acq), .SET_INDEX(idx),
      .ACTIVE_PARAM(act), .IRQ(irq));
   lgs_src SRC (.clk(clk), .acq_start(acq), .frame_trig(trig), .ctrl_line(line), .frame_done(done));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) if (acq === 1'b1) n_acq++;
   // ========
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // one transfer; readies are looked at mid-cycle so no edge race
   task automatic axi(input bit w, input logic [7:0] a, input logic [31:0] d = 0);
      int n;
      logic fin, ta, tw, tr;
      n = 0;
      fin = 1'b0;
      @(posedge clk);
      if (w) begin
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
      end else begin
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
      end
      while (!fin && n < 100) begin
         @(negedge clk);
         ta = awready;
         tw = wready;
         tr = arready;
         fin = w ? bvalid : rvalid;
         rsp = w ? bresp : rresp;
         rdat = rdata;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tr) arvalid <= 1'b0;
         n++;
      end
      bready <= 1'b0;
      rready <= 1'b0;
      if (!fin) begin
         chk("timeout", 1, 0);
         finish_test();
      end
   endtask
   // one frame: settle line, wait for status, trigger, compare with model
   task automatic shot(input logic v, input int dly);
      int n;
      n = 0;
      SRC.done_dly = dly;
      SRC.set_line(v, 110);
      while (n < 300) begin
         @(negedge clk);
         if (wait_t === 1'b1) break;
         n++;
      end
      if (n == 300) begin
         chk("timeout", 1, 0);
         finish_test();
      end
      n0 = n_acq;
      SRC.pulse();
      chk("acq", n0 + 1, n_acq);
      if (v ^ inv_m) idx_m = (idx_m + 1 == tot_m) ? 0 : idx_m + 1;
      chk("idx", idx_m, idx);
      chk("act", mem[idx_m], act);
   endtask
   // ========
   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata} = '0;
      {n_acq, fails, n_checks, idx_m} = '0;
      inv_m = 1'b0;
      rst_n = 1'b0;
      k = $urandom(32'hBCD5);
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      axi(0, ADR_TOTAL);
      chk("total_rst", 32'(TOTAL_RST), rdat);
      axi(1, ADR_TOTAL, 100);
      axi(0, ADR_TOTAL);
      chk("total_max", 32'h40, rdat);
      axi(1, 8'h40, 1);
      chk("bresp", 32'(RESP_SLVERR), 32'(rsp));
      axi(0, 8'h44);
      chk("rresp", 32'(RESP_SLVERR), 32'(rsp));
      axi(1, ADR_TOTAL, 6);
      tot_m = 6;
      for (k = 0; k < 6; k++) begin
         mem[k] = $urandom;
         axi(1, ADR_SET_SEL, k);
         axi(1, ADR_SET_DAT, mem[k]);
      end
      base_m = $urandom;
      axi(1, ADR_BASE, base_m);
      axi(1, ADR_IRQ_ST, 32'hF);
      // line high at enable must not count as an advance
      SRC.set_line(1'b1, 110);
      axi(1, ADR_CTRL, 1);
      repeat (3) @(negedge clk);
      chk("en_idx", 0, idx);
      chk("en_act", mem[0], act);
      for (k = 0; k < 10; k++) shot(pat[k], 1 + $urandom % 20);
      axi(0, ADR_IRQ_ST);
      chk("wrap_st", 1, rdat[EV_WRAP]);
      chk("irq_off", 0, irq);
      axi(1, ADR_IRQ_MSK, 32'h4);
      repeat (2) @(negedge clk);
      chk("irq_on", 1, irq);
      axi(1, ADR_IRQ_ST, 32'hF);
      repeat (2) @(negedge clk);
      chk("irq_clr", 0, irq);
      // trigger thrown in while the line is still settling
      n0 = n_acq;
      SRC.set_line(!line, 3);
      SRC.pulse();
      chk("ign_acq", n0, n_acq);
      chk("ign_idx", idx_m, idx);
      axi(0, ADR_IRQ_ST);
      chk("ign_st", 1, rdat[EV_IGNORE]);
      axi(1, ADR_CTRL, 3);
      inv_m = 1'b1;
      shot(1'b0, 7);
      shot(1'b1, 3);
      axi(0, ADR_STATUS);
      chk("stat_idx", idx_m, rdat[7:2]);
      // slow frame: disable lands mid acquisition
      shot(1'b0, 300);
      axi(1, ADR_CTRL, 0);
      chk("dis_act", mem[idx_m], act);
      repeat (250) @(negedge clk);
      chk("rest_act", base_m, act);
      chk("rest_wait", 0, wait_t);
      axi(0, ADR_IRQ_ST);
      chk("stop_st", 1, rdat[EV_STOP]);
      finish_test();
   end
endmodule
bind lgs_seq lgs_seq_props PROPS (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .S_AXI_ARVALID(S_AXI_ARVALID),
   .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_BVALID(S_AXI_BVALID),
   .S_AXI_BREADY(S_AXI_BREADY), .CTRL_LINE(CTRL_LINE), .WAIT_TRIG(WAIT_TRIG), .ACQ_START(ACQ_START),
   .SET_INDEX(SET_INDEX));
`default_nettype wire

// file: test/lgs_src.sv
// lgs_src: far side model: frame trigger, control line, frame done.
// assumes the bench calls set_line and pulse and sets done_dly.
`timescale 1ns/1ns
`default_nettype none
module lgs_src (
   input  wire logic clk,
   input  wire logic acq_start,
   output logic      frame_trig,
   output logic      ctrl_line,
   output logic      frame_done
);
   int done_dly = 5;
   int cnt_ff = 0;
   initial begin
      frame_trig = 1'b0;
      ctrl_line = 1'b0;
      frame_done = 1'b0;
   end
   // ========
   // exposure and readout end a set time after each start
   always @(posedge clk) begin
      frame_done <= (cnt_ff == 1);
      if (acq_start === 1'b1) cnt_ff <= done_dly;
      else if (cnt_ff > 0) cnt_ff <= cnt_ff - 1;
   end
   // ========
   // line is left quiet for hold cycles before a trigger may follow
   task automatic set_line(input logic v, input int hold);
      @(posedge clk);
      ctrl_line <= v;
      repeat (hold) @(posedge clk);
   endtask
   // line stays put well past the trigger so the sample is clean
   task automatic pulse();
      @(posedge clk);
      frame_trig <= 1'b1;
      repeat (4) @(posedge clk);
      frame_trig <= 1'b0;
      repeat (100) @(posedge clk);
   endtask
endmodule
`default_nettype wire
